// ===== verif/status_page_voice_detect_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module status_page_voice_detect_regs_tb;
    import svd_pkg::*;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic reg_wr_en, reg_rd_en;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
    logic device_sleep = 1'h1;
    logic [3:0] channel_enable = 4'h0;
    logic speech_event = 1'h0, silence_event = 1'h0, detector_irq = 1'h1, asi_serial_data = 1'h0;
    logic [1:0] voice_power_policy, voice_monitor_channel, voice_clock_source, voice_ext_clock_rate;
    logic voice_detect_run, converter_active, serial_out_irq_mode, serial_data_output_pin;
    int n_fail = 0;
    int num_checks = 0;
    always #10 clk = ~clk;
    svd_regs dut (.*);
    svd_host host (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        host.rd(a, rd_val);
        chk(rd_val, exp);
    endtask
    // levels pass through two register stages, so allow three cycles
    task automatic lv(input logic [3:0] e);
        repeat (3) @(negedge clk);
        chk({4'h0, converter_active, voice_detect_run, serial_out_irq_mode,
            serial_data_output_pin}, {4'h0, e});
    endtask
    task automatic t_reset();
        rchk(OFS_DEVICE_STATE, 8'h80);
        rchk(OFS_CHECKSUM, 8'h00);
        rchk(OFS_PAGE_SELECT, 8'h00);
        host.wr(OFS_PAGE_SELECT, PAGE_ONE);
        rchk(OFS_VOICE_CFG_ONE, 8'h20);
        rchk(OFS_VOICE_CFG_TWO, 8'h08);
        rchk(7'h20, 8'h00);
    endtask
    task automatic t_fields();
        for (int i = 0; i < 4; i++) begin
            host.wr(OFS_VOICE_CFG_ONE, 8'(i * 8'h55));
            chk({voice_power_policy, voice_monitor_channel, voice_clock_source,
                voice_ext_clock_rate}, 8'(i * 8'h55));
            rchk(OFS_VOICE_CFG_ONE, 8'(i * 8'h55));
        end
        host.wr(OFS_VOICE_CFG_TWO, 8'h48);
        rchk(OFS_VOICE_CFG_TWO, 8'h48);
    endtask
    task automatic t_cksum();
        host.wr(OFS_PAGE_SELECT, PAGE_ZERO);
        host.wr(OFS_CHECKSUM, 8'hF0);
        host.wr(OFS_POWER_CONFIG, 8'h20);
        host.wr(OFS_PAGE_SELECT, 8'h02);
        host.wr(OFS_VOICE_CFG_ONE, 8'h05);
        host.wr(OFS_PAGE_SELECT, PAGE_ZERO);
        rchk(OFS_CHECKSUM, 8'h17);
        chk({voice_power_policy, voice_monitor_channel, voice_clock_source,
            voice_ext_clock_rate}, 8'hFF);
    endtask
    task automatic t_power();
        host.wr(OFS_PAGE_SELECT, PAGE_ONE);
        host.wr(OFS_VOICE_CFG_ONE, 8'h20);
        host.wr(OFS_PAGE_SELECT, PAGE_ZERO);
        device_sleep = 1'h0;
        channel_enable = 4'h1;
        host.wr(OFS_POWER_CONFIG, 8'h41);
        lv(4'hC);
        rchk(OFS_DEVICE_STATE, 8'hE0);
        channel_enable = 4'h0;
        lv(4'hF);
        rchk(OFS_DEVICE_STATE, 8'hC0);
        host.wr(OFS_POWER_CONFIG, 8'h01);
        lv(4'h7);
        host.wr(OFS_POWER_CONFIG, 8'h00);
        lv(4'h3);
        host.wr(OFS_PAGE_SELECT, PAGE_ONE);
        host.wr(OFS_VOICE_CFG_ONE, 8'h60);
        host.wr(OFS_VOICE_CFG_TWO, 8'h40);
        host.wr(OFS_PAGE_SELECT, PAGE_ZERO);
        host.wr(OFS_POWER_CONFIG, 8'h41);
        lv(4'h7);
        channel_enable = 4'h1;
        @(negedge clk) speech_event = 1'h1;
        @(negedge clk) speech_event = 1'h0;
        lv(4'h8);
        // detection is held off while recording, so silence must not power down
        @(negedge clk) silence_event = 1'h1;
        @(negedge clk) silence_event = 1'h0;
        lv(4'h8);
        channel_enable = 4'h0;
        lv(4'hF);
        @(negedge clk) silence_event = 1'h1;
        @(negedge clk) silence_event = 1'h0;
        lv(4'h7);
        device_sleep = 1'h1;
        lv(4'h3);
        rchk(OFS_DEVICE_STATE, 8'h80);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        srst = 1'h0;
        t_reset();
        t_fields();
        t_cksum();
        t_power();
        conclude();
    end
    initial begin
        #200us;
        n_fail++;
        conclude();
    end
endmodule // status_page_voice_detect_regs_tb
bind svd_regs svd_regs_chk chk (.*);
`default_nettype wire

// ===== verif/svd_host.sv
`timescale 1ns/1ps
`default_nettype none
module svd_host
    import svd_pkg::*;
(
    input wire logic clk,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata
);
    initial begin
        reg_wr_en = 1'h0;
        reg_rd_en = 1'h0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end
    // callers write mapped offsets except page 2 offset 0x1E in the checksum test, reserved bits at reset value
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge clk);
        reg_wr_en = 1'h1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr_en = 1'h0;
        // released lines never keep the old value
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(negedge clk);
        reg_rd_en = 1'h1;
        reg_addr = a;
        @(negedge clk);
        reg_rd_en = 1'h0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule // svd_host
`default_nettype wire

// ===== verif/svd_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module svd_regs_chk
    import svd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic device_sleep,
    input wire logic speech_event,
    input wire logic silence_event,
    input wire logic detector_irq,
    input wire logic asi_serial_data,
    input wire logic [1:0] voice_power_policy,
    input wire logic [1:0] voice_monitor_channel,
    input wire logic [1:0] voice_clock_source,
    input wire logic [1:0] voice_ext_clock_rate,
    input wire logic voice_detect_run,
    input wire logic converter_active,
    input wire logic serial_out_irq_mode,
    input wire logic serial_data_output_pin
);
    // page is tracked here so that write decodes need no internal probes
    logic [7:0] page_q;
    logic [7:0] page_d;
    wire logic [7:0] cfg1 = {voice_power_policy, voice_monitor_channel, voice_clock_source,
        voice_ext_clock_rate};
    wire logic cfg1_wr = reg_wr_en && page_q == PAGE_ONE && reg_addr == OFS_VOICE_CFG_ONE;
    wire logic pw_wr = reg_wr_en && page_q == PAGE_ZERO && reg_addr == OFS_POWER_CONFIG;
    always_comb begin
        page_d = page_q;
        if (reg_wr_en && reg_addr == OFS_PAGE_SELECT) begin
            page_d = reg_wdata;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            page_q <= PAGE_ZERO;
        end else begin
            page_q <= page_d;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    rdata_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    cfg1_load_a: assert property (cfg1_wr |=> cfg1 == $past(reg_wdata))
        else $error("config one fields not loaded");
    cfg1_keep_a: assert property (!cfg1_wr |=> $stable(cfg1))
        else $error("config one fields changed without a write");
    reset_val_a: assert property (disable iff (1'b0) srst |=> cfg1 == RST_VOICE_CFG_ONE
        && !converter_active) else $error("wrong values after reset");
    pin_route_a: assert property (!$past(srst) && $past(serial_out_irq_mode) ==
        serial_out_irq_mode |-> serial_data_output_pin == (serial_out_irq_mode ?
        $past(detector_irq) : $past(asi_serial_data))) else $error("serial pin misrouted");
    sleep_off_a: assert property (device_sleep |=> !converter_active && !voice_detect_run)
        else $error("sleep did not stop converters");
    user_on_a: assert property (pw_wr && reg_wdata[CONV_POWER_BIT] && !device_sleep &&
        voice_power_policy == SVD_POL_USER |=> converter_active) else $error("user power-up lost");
    speech_on_a: assert property (speech_event && voice_detect_run && !device_sleep &&
        voice_power_policy == SVD_POL_DETECT_BOTH |=> converter_active)
        else $error("speech did not power up");
    silence_off_a: assert property (silence_event && voice_detect_run &&
        voice_power_policy == SVD_POL_DETECT_BOTH |=> !converter_active)
        else $error("silence did not power down");
endmodule // svd_regs_chk
`default_nettype wire

// ===== verilog/svd_pkg.sv
// Summary of operation
// - read-only mode code in bits 7-5: 4 sleep, 6 all off, 7 some on
// - eight-bit bus checksum readable; a write to it loads the written value
// - every write to any other register on any page updates the checksum
// - offset 0x0 of every page holds the page select used by later accesses
// - page 1 offset 0x1E config one resets 0x20, 0x1F config two resets 0x08
// - power policy bits 7-6: user, detector both, detector up, detector down
// - monitored channel bits 5-4 pick channel 1 to 4, reset selects channel 3
// - clock source bits 3-2: oscillator, bit clock, master clock, custom
// - external clock rate bits 1-0: 3.072, 6.144, 12.288, 18.432 MHz
// - config two bit 6 turns the serial output into an interrupt when idle
// - config two bit 3 keeps detection running during recording, reset set
// - detection runs only while the page-0 detect enable bit is set
// - page-0 converter power bit clear powers all channels down (user, detector up policies), set powers up (user, detector down)
package svd_pkg;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;

    // ----------------------------------------------------------------
    // pages and offsets
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] PAGE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] PAGE_ONE = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_PAGE_SELECT = 7'h00;
    localparam logic [ADDR_W-1:0] OFS_POWER_CONFIG = 7'h75;
    localparam logic [ADDR_W-1:0] OFS_DEVICE_STATE = 7'h77;
    localparam logic [ADDR_W-1:0] OFS_CHECKSUM = 7'h7E;
    localparam logic [ADDR_W-1:0] OFS_VOICE_CFG_ONE = 7'h1E;
    localparam logic [ADDR_W-1:0] OFS_VOICE_CFG_TWO = 7'h1F;

    // ----------------------------------------------------------------
    // reset values and masks
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_PAGE_SELECT = 8'h00;
    localparam logic [DATA_W-1:0] RST_POWER_CONFIG = 8'h00;
    localparam logic [DATA_W-1:0] RST_CHECKSUM = 8'h00;
    localparam logic [DATA_W-1:0] RST_VOICE_CFG_ONE = 8'h20;
    localparam logic [DATA_W-1:0] RST_VOICE_CFG_TWO = 8'h08;
    // bits 5 and 2-0 of config two are read-only
    localparam logic [DATA_W-1:0] VOICE_CFG_TWO_WMASK = 8'hD8;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned POLICY_LSB = 6;
    localparam int unsigned CHANNEL_LSB = 4;
    localparam int unsigned CLKSRC_LSB = 2;
    localparam int unsigned EXTRATE_LSB = 0;
    localparam int unsigned IRQ_EN_BIT = 6;
    localparam int unsigned DET_REC_BIT = 3;
    localparam int unsigned CONV_POWER_BIT = 6;
    localparam int unsigned DET_EN_BIT = 0;
    localparam int unsigned STATE_LSB = 5;

    // ----------------------------------------------------------------
    // codes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SVD_POL_USER = 2'h0,
        SVD_POL_DETECT_BOTH = 2'h1,
        SVD_POL_DETECT_UP = 2'h2,
        SVD_POL_DETECT_DOWN = 2'h3
    } svd_policy_t;

    localparam logic [2:0] STATE_SLEEP = 3'h4;
    localparam logic [2:0] STATE_ACTIVE_OFF = 3'h6;
    localparam logic [2:0] STATE_ACTIVE_ON = 3'h7;
endpackage

// ===== verilog/svd_regs.sv
`timescale 1ns/1ps
`default_nettype none
module svd_regs
    import svd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic device_sleep,
    input wire logic [3:0] channel_enable,
    input wire logic speech_event,
    input wire logic silence_event,
    input wire logic detector_irq,
    input wire logic asi_serial_data,
    output logic [1:0] voice_power_policy,
    output logic [1:0] voice_monitor_channel,
    output logic [1:0] voice_clock_source,
    output logic [1:0] voice_ext_clock_rate,
    output logic voice_detect_run,
    output logic converter_active,
    output logic serial_out_irq_mode,
    output logic serial_data_output_pin
);
    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] page_select_q, page_select_d;
    logic [DATA_W-1:0] power_config_q, power_config_d;
    logic [DATA_W-1:0] checksum_q, checksum_d;
    logic [DATA_W-1:0] voice_cfg_one_q, voice_cfg_one_d;
    logic [DATA_W-1:0] voice_cfg_two_q, voice_cfg_two_d;
    logic active_q, active_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic pin_q, pin_d;
    logic irq_mode_q, irq_mode_d;
    logic run_q, run_d;

    function automatic logic hit(input logic [DATA_W-1:0] page,
                                 input logic [ADDR_W-1:0] addr,
                                 input logic [DATA_W-1:0] want_page,
                                 input logic [ADDR_W-1:0] want_addr);
        hit = (page == want_page) && (addr == want_addr);
    endfunction

    logic wr_page, wr_power, wr_cksum, wr_cfg1, wr_cfg2;
    svd_policy_t policy;
    logic any_channel;
    logic recording;
    logic [2:0] state_code;

    assign wr_page = reg_wr_en && (reg_addr == OFS_PAGE_SELECT);
    assign wr_power = reg_wr_en && hit(page_select_q, reg_addr, PAGE_ZERO, OFS_POWER_CONFIG);
    assign wr_cksum = reg_wr_en && hit(page_select_q, reg_addr, PAGE_ZERO, OFS_CHECKSUM);
    assign wr_cfg1 = reg_wr_en && hit(page_select_q, reg_addr, PAGE_ONE, OFS_VOICE_CFG_ONE);
    assign wr_cfg2 = reg_wr_en && hit(page_select_q, reg_addr, PAGE_ONE, OFS_VOICE_CFG_TWO);

    assign policy = svd_policy_t'(voice_cfg_one_q[POLICY_LSB +: 2]);
    assign any_channel = |channel_enable;
    assign recording = active_q && any_channel;

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    always_comb begin
        page_select_d = page_select_q;
        power_config_d = power_config_q;
        checksum_d = checksum_q;
        voice_cfg_one_d = voice_cfg_one_q;
        voice_cfg_two_d = voice_cfg_two_q;
        if (wr_page) begin
            page_select_d = reg_wdata;
        end
        if (wr_power) begin
            power_config_d = reg_wdata;
        end
        if (wr_cfg1) begin
            voice_cfg_one_d = reg_wdata;
        end
        if (wr_cfg2) begin
            // read-only reserved bits keep their reset value
            voice_cfg_two_d = (reg_wdata & VOICE_CFG_TWO_WMASK)
                | (RST_VOICE_CFG_TWO & ~VOICE_CFG_TWO_WMASK);
        end
        if (wr_cksum) begin
            checksum_d = reg_wdata;
        end else if (reg_wr_en) begin
            // every other write, any page, reserved offsets too
            checksum_d = checksum_q + reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            page_select_q <= RST_PAGE_SELECT;
            power_config_q <= RST_POWER_CONFIG;
            checksum_q <= RST_CHECKSUM;
            voice_cfg_one_q <= RST_VOICE_CFG_ONE;
            voice_cfg_two_q <= RST_VOICE_CFG_TWO;
        end else begin
            page_select_q <= page_select_d;
            power_config_q <= power_config_d;
            checksum_q <= checksum_d;
            voice_cfg_one_q <= voice_cfg_one_d;
            voice_cfg_two_q <= voice_cfg_two_d;
        end
    end

    // ----------------------------------------------------------------
    // converter power
    // ----------------------------------------------------------------
    // user actions act only at the write; detector events only while detection runs,
    // so a stale event cannot power the converters behind software's back
    always_comb begin
        active_d = active_q;
        if (wr_power) begin
            if (reg_wdata[CONV_POWER_BIT]
                && (policy == SVD_POL_USER || policy == SVD_POL_DETECT_DOWN)) begin
                active_d = 1'b1;
            end
            if (!reg_wdata[CONV_POWER_BIT]
                && (policy == SVD_POL_USER || policy == SVD_POL_DETECT_UP)) begin
                active_d = 1'b0;
            end
        end
        if (run_q && speech_event
            && (policy == SVD_POL_DETECT_BOTH || policy == SVD_POL_DETECT_UP)) begin
            active_d = 1'b1;
        end
        if (run_q && silence_event
            && (policy == SVD_POL_DETECT_BOTH || policy == SVD_POL_DETECT_DOWN)) begin
            active_d = 1'b0;
        end
        if (device_sleep) begin
            active_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            active_q <= 1'b0;
        end else begin
            active_q <= active_d;
        end
    end

    // ----------------------------------------------------------------
    // detector control and serial output pin
    // ----------------------------------------------------------------
    always_comb begin
        run_d = power_config_q[DET_EN_BIT] && !device_sleep
            && (!recording || voice_cfg_two_q[DET_REC_BIT]);
        irq_mode_d = voice_cfg_two_q[IRQ_EN_BIT] && !recording;
        pin_d = irq_mode_d ? detector_irq : asi_serial_data;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            run_q <= 1'b0;
            irq_mode_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            run_q <= run_d;
            irq_mode_q <= irq_mode_d;
            pin_q <= pin_d;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        if (device_sleep) begin
            state_code = STATE_SLEEP;
        end else if (recording) begin
            state_code = STATE_ACTIVE_ON;
        end else begin
            state_code = STATE_ACTIVE_OFF;
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd_en) begin
            rdata_d = '0;
            if (reg_addr == OFS_PAGE_SELECT) begin
                rdata_d = page_select_q;
            end else if (hit(page_select_q, reg_addr, PAGE_ZERO, OFS_POWER_CONFIG)) begin
                rdata_d = power_config_q;
            end else if (hit(page_select_q, reg_addr, PAGE_ZERO, OFS_DEVICE_STATE)) begin
                rdata_d = {state_code, 5'b0_0000};
            end else if (hit(page_select_q, reg_addr, PAGE_ZERO, OFS_CHECKSUM)) begin
                rdata_d = checksum_q;
            end else if (hit(page_select_q, reg_addr, PAGE_ONE, OFS_VOICE_CFG_ONE)) begin
                rdata_d = voice_cfg_one_q;
            end else if (hit(page_select_q, reg_addr, PAGE_ONE, OFS_VOICE_CFG_TWO)) begin
                rdata_d = voice_cfg_two_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign voice_power_policy = voice_cfg_one_q[POLICY_LSB +: 2];
    assign voice_monitor_channel = voice_cfg_one_q[CHANNEL_LSB +: 2];
    assign voice_clock_source = voice_cfg_one_q[CLKSRC_LSB +: 2];
    assign voice_ext_clock_rate = voice_cfg_one_q[EXTRATE_LSB +: 2];
    assign voice_detect_run = run_q;
    assign converter_active = active_q;
    assign serial_out_irq_mode = irq_mode_q;
    assign serial_data_output_pin = pin_q;
endmodule // svd_regs
`default_nettype wire
